//--- design/accel_ctrl_defines.svh
`ifndef ACCEL_CTRL_DEFINES_SVH
`define ACCEL_CTRL_DEFINES_SVH

// bus address, value arbitrary
`define DEV_ADDR 7'h2a

`define OFS_X     8'h00
`define OFS_Y     8'h01
`define OFS_Z     8'h02
`define OFS_TILT  8'h03
`define OFS_STAT  8'h04
`define OFS_LIMIT 8'h05
`define OFS_EVEN  8'h06
`define OFS_MODE  8'h07
`define OFS_RATE  8'h08

`define MODE_RUN   0
`define MODE_TEST  2
`define MODE_AWE   3
`define MODE_ASE   4
`define MODE_SLEEP_PRESCALE_SELECT  5
`define MODE_DRIVE 6
`define MODE_POL   7

`define EN_FB  0
`define EN_PL  1
`define EN_TAP 2
`define EN_SLP 3
`define EN_SMP 4

`define RST_BYTE   8'h00
`define BYTE_BITS  4'h8
`define LAST_BIT   4'h7
`define PRESC_LAST 4'hf

`endif

//--- design/accel_ctrl_pkg.sv
package accel_ctrl_pkg;

  typedef enum logic [5:0] {
    ST_STANDBY    = 6'h01,
    ST_TEST       = 6'h02,
    ST_RUN_ACT    = 6'h04,
    ST_AUTO_SLEEP = 6'h08,
    ST_RUN_WAKE   = 6'h10,
    ST_AUTO_WAKE  = 6'h20
  } op_state_t;

  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_ADDR = 6'h02,
    PH_ACK  = 6'h04,
    PH_RX   = 6'h08,
    PH_TX   = 6'h10,
    PH_RACK = 6'h20
  } link_phase_t;

  typedef struct packed {
    logic       sample_tick;
    logic [5:0] x;
    logic [5:0] y;
    logic [5:0] z;
    logic       orient_valid;
    logic [1:0] front_back;
    logic [2:0] up_down;
    logic       tap;
    logic [2:0] shake_xyz;
  } sense_in_t;

  typedef struct packed {
    logic [5:0] x;
    logic [5:0] y;
    logic [5:0] z;
  } axis_results_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef struct packed {
    op_state_t     op;
    link_phase_t   ph;
    logic [7:0]    limit;
    logic [7:0]    ev_en;
    logic [7:0]    mode;
    logic [7:0]    rate;
    logic [7:0]    tilt;
    axis_results_t res;
    logic [7:0]    cnt;
    logic [3:0]    presc;
    logic          ev_hold;
    logic [7:0]    shift;
    logic [7:0]    ptr;
    logic [3:0]    bits;
    logic          rnw;
    logic          ptr_done;
    logic          scl_q;
    logic          sda_q;
    logic          sda_oe_n;
    logic [7:0]    sps;
    logic          act_on;
    logic          wake_on;
  } ctrl_state_t;

endpackage : accel_ctrl_pkg

//--- design/event_pin_driver.sv
`timescale 1ns/1ps
module event_pin_driver (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic asserted,
  input  wire logic polarity,
  input  wire logic push_pull,
  output logic      pin_out,
  output logic      pin_oe_n
);

  accel_ctrl_pkg::pin_drive_t drv_reg;
  accel_ctrl_pkg::pin_drive_t drv_next;
  logic                       lvl;

  always_comb begin
    lvl = polarity ? asserted : ~asserted;
    if (push_pull) begin
      drv_next.out  = lvl;
      drv_next.oe_n = 1'b0;
    end else begin
      // open drain only ever pulls low
      drv_next.out  = 1'b0;
      drv_next.oe_n = lvl;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drv_reg <= '{out: 1'b0, oe_n: 1'b1};
    end else begin
      drv_reg <= drv_next;
    end
  end

  assign pin_out  = drv_reg.out;
  assign pin_oe_n = drv_reg.oe_n;

endmodule : event_pin_driver

//--- design/accel_mode_sleep_event_ctrl.sv
// Operation
// - status bits show which sample rate runs
// - sleep limit write clears sleep counter
// - counter reaching limit leaves auto-sleep
// - front/back change raises event when enabled
// - portrait/landscape change raises event when enabled
// - tap raises event when enabled
// - leaving auto-sleep raises event when enabled
// - every sample update raises event when enabled
// - enabled shake raises event, sets shake flag
// - event released at address acknowledge
// - mode access restarts sleep; write clears results
// - run and test bits decode three modes
// - test mode entered only from standby
// - active entry at active rate, sleep first
// - test mode takes written results, no shake
// - auto-wake at wake rate, event exits
// - auto-sleep at active rate, timeout exits
// - sleep counter prescale by one or sixteen
// - event pin open-drain or push-pull
// - event pin polarity selectable
// - active rate code 001 means 64
`timescale 1ns/1ps
`include "accel_ctrl_defines.svh"
module accel_mode_sleep_event_ctrl (
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_n,
  input  wire accel_ctrl_pkg::sense_in_t     sense,
  output accel_ctrl_pkg::axis_results_t      axis_results,
  output logic [7:0]                         orientation_status,
  output logic                               active_rate_in_use,
  output logic                               wake_rate_in_use,
  output logic [7:0]                         active_rate_sps,
  output logic                               event_out,
  output logic                               event_oe_n
);

  accel_ctrl_pkg::ctrl_state_t s_reg;
  accel_ctrl_pkg::ctrl_state_t s_next;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic       ev_release;
  logic       wr_stb;
  logic [7:0] wr_ofs;
  logic [7:0] wr_dat;
  logic       mode_touch;
  logic       cfg_open;
  logic       running;
  logic       in_test;
  logic       fb_chg;
  logic       pl_chg;
  logic [2:0] shake_en;
  logic       ev_fb;
  logic       ev_pl;
  logic       ev_tap;
  logic       ev_shake;
  logic       ev_smp;
  logic       ev_slp;
  logic       wake_ev;
  logic       presc_tick;
  logic       act_use;
  logic       wake_use;
  logic [7:0] tx_byte;

  ////////////////////////////////////////////////////////////////
  // read multiplexer

  function automatic logic [7:0] rd_mux(
    input accel_ctrl_pkg::ctrl_state_t st,
    input logic [7:0]                  ofs
  );
    logic [7:0] v;
    v = `RST_BYTE;
    case (ofs)
      `OFS_X:     v = {2'h0, st.res.x};
      `OFS_Y:     v = {2'h0, st.res.y};
      `OFS_Z:     v = {2'h0, st.res.z};
      `OFS_TILT:  v = st.tilt;
      `OFS_STAT:  v = {6'h00, st.op == accel_ctrl_pkg::ST_RUN_WAKE
                       || st.op == accel_ctrl_pkg::ST_AUTO_WAKE,
                       st.op == accel_ctrl_pkg::ST_RUN_ACT
                       || st.op == accel_ctrl_pkg::ST_AUTO_SLEEP};
      `OFS_LIMIT: v = st.limit;
      `OFS_EVEN:  v = st.ev_en;
      `OFS_MODE:  v = st.mode;
      `OFS_RATE:  v = st.rate;
      default:    v = `RST_BYTE;
    endcase
    return v;
  endfunction : rd_mux

  function automatic logic [7:0] sps_of(input logic [2:0] code);
    logic [7:0] v;
    v = 8'h01;
    case (code)
      3'h0:    v = 8'h78;
      3'h1:    v = 8'h40;
      3'h2:    v = 8'h20;
      3'h3:    v = 8'h10;
      3'h4:    v = 8'h08;
      3'h5:    v = 8'h04;
      3'h6:    v = 8'h02;
      default: v = 8'h01;
    endcase
    return v;
  endfunction : sps_of

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_next     = s_reg;
    ev_release = 1'b0;
    wr_stb     = 1'b0;
    wr_ofs     = `RST_BYTE;
    wr_dat     = `RST_BYTE;
    mode_touch = 1'b0;
    tx_byte    = rd_mux(s_reg, s_reg.ptr);

    scl_rise = scl_in & ~s_reg.scl_q;
    scl_fall = ~scl_in & s_reg.scl_q;
    start_c  = s_reg.scl_q & scl_in & s_reg.sda_q & ~sda_in;
    stop_c   = s_reg.scl_q & scl_in & ~s_reg.sda_q & sda_in;
    s_next.scl_q = scl_in;
    s_next.sda_q = sda_in;

    // serial link
    if (stop_c) begin
      s_next.ph       = accel_ctrl_pkg::PH_IDLE;
      s_next.sda_oe_n = 1'b1;
    end else if (start_c) begin
      s_next.ph       = accel_ctrl_pkg::PH_ADDR;
      s_next.bits     = 4'h0;
      s_next.ptr_done = 1'b0;
      s_next.sda_oe_n = 1'b1;
    end else begin
      unique case (s_reg.ph)
        accel_ctrl_pkg::PH_IDLE: begin
        end
        accel_ctrl_pkg::PH_ADDR: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda_in};
            s_next.bits  = s_reg.bits + 4'h1;
          end else if (scl_fall && s_reg.bits == `BYTE_BITS) begin
            s_next.bits = 4'h0;
            if (s_reg.shift[7:1] == `DEV_ADDR) begin
              s_next.ph       = accel_ctrl_pkg::PH_ACK;
              s_next.sda_oe_n = 1'b0;
              s_next.rnw      = s_reg.shift[0];
              ev_release      = 1'b1;
            end else begin
              s_next.ph = accel_ctrl_pkg::PH_IDLE;
            end
          end
        end
        accel_ctrl_pkg::PH_ACK: begin
          if (scl_fall) begin
            s_next.bits = 4'h0;
            if (s_reg.rnw) begin
              s_next.shift    = tx_byte;
              s_next.sda_oe_n = tx_byte[7];
              s_next.ptr      = s_reg.ptr + 8'h01;
              mode_touch      = (s_reg.ptr == `OFS_MODE);
              s_next.ph       = accel_ctrl_pkg::PH_TX;
            end else begin
              s_next.sda_oe_n = 1'b1;
              s_next.ph       = accel_ctrl_pkg::PH_RX;
            end
          end
        end
        accel_ctrl_pkg::PH_RX: begin
          if (scl_rise) begin
            s_next.shift = {s_reg.shift[6:0], sda_in};
            s_next.bits  = s_reg.bits + 4'h1;
          end else if (scl_fall && s_reg.bits == `BYTE_BITS) begin
            s_next.ph       = accel_ctrl_pkg::PH_ACK;
            s_next.sda_oe_n = 1'b0;
            s_next.bits     = 4'h0;
            if (!s_reg.ptr_done) begin
              s_next.ptr      = s_reg.shift;
              s_next.ptr_done = 1'b1;
            end else begin
              wr_stb     = 1'b1;
              wr_ofs     = s_reg.ptr;
              wr_dat     = s_reg.shift;
              s_next.ptr = s_reg.ptr + 8'h01;
            end
          end
        end
        accel_ctrl_pkg::PH_TX: begin
          if (scl_fall) begin
            if (s_reg.bits == `LAST_BIT) begin
              s_next.ph       = accel_ctrl_pkg::PH_RACK;
              s_next.sda_oe_n = 1'b1;
            end else begin
              s_next.shift    = {s_reg.shift[6:0], 1'b0};
              s_next.sda_oe_n = s_reg.shift[6];
              s_next.bits     = s_reg.bits + 4'h1;
            end
          end
        end
        accel_ctrl_pkg::PH_RACK: begin
          if (scl_rise && sda_in) begin
            s_next.ph = accel_ctrl_pkg::PH_IDLE;
          end else if (scl_fall) begin
            s_next.bits     = 4'h0;
            s_next.shift    = tx_byte;
            s_next.sda_oe_n = tx_byte[7];
            s_next.ptr      = s_reg.ptr + 8'h01;
            mode_touch      = (s_reg.ptr == `OFS_MODE);
            s_next.ph       = accel_ctrl_pkg::PH_TX;
          end
        end
      endcase
    end

    // sensing and events
    running  = s_reg.op != accel_ctrl_pkg::ST_STANDBY;
    in_test  = s_reg.op == accel_ctrl_pkg::ST_TEST;
    act_use  = s_reg.op == accel_ctrl_pkg::ST_RUN_ACT
               || s_reg.op == accel_ctrl_pkg::ST_AUTO_SLEEP;
    wake_use = s_reg.op == accel_ctrl_pkg::ST_RUN_WAKE
               || s_reg.op == accel_ctrl_pkg::ST_AUTO_WAKE;
    fb_chg   = sense.front_back != s_reg.tilt[1:0];
    pl_chg   = sense.up_down != s_reg.tilt[4:2];
    // no shake in test mode
    shake_en = s_reg.ev_en[7:5] & sense.shake_xyz & {3{~in_test}};
    ev_fb    = running & sense.orient_valid & fb_chg
               & s_reg.ev_en[`EN_FB];
    ev_pl    = running & sense.orient_valid & pl_chg
               & s_reg.ev_en[`EN_PL];
    ev_tap   = running & sense.orient_valid & sense.tap
               & s_reg.ev_en[`EN_TAP];
    ev_shake = running & sense.orient_valid & (|shake_en);
    wake_ev  = ev_fb | ev_pl | ev_tap | ev_shake;
    ev_smp   = 1'b0;
    ev_slp   = 1'b0;

    if (running && sense.orient_valid) begin
      s_next.tilt = {|shake_en, 1'b0, sense.tap,
                     sense.up_down, sense.front_back};
    end

    // measured results only outside test mode
    if ((act_use || wake_use) && sense.sample_tick) begin
      s_next.res = '{x: sense.x, y: sense.y, z: sense.z};
      ev_smp     = s_reg.ev_en[`EN_SMP];
    end

    // sleep counter
    presc_tick = ~s_reg.mode[`MODE_SLEEP_PRESCALE_SELECT]
                 | (s_reg.presc == `PRESC_LAST);
    if (s_reg.op == accel_ctrl_pkg::ST_AUTO_SLEEP && sense.sample_tick) begin
      s_next.presc = s_reg.presc + 4'h1;
      if (presc_tick) begin
        if (s_reg.cnt == s_reg.limit) begin
          s_next.cnt = 8'h00;
          ev_slp     = s_reg.ev_en[`EN_SLP];
          s_next.op  = s_reg.mode[`MODE_AWE]
                       ? accel_ctrl_pkg::ST_AUTO_WAKE
                       : accel_ctrl_pkg::ST_RUN_WAKE;
        end else begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
      end
    end

    // enabled event ends auto-wake; per-sample event does not
    if (s_reg.op == accel_ctrl_pkg::ST_AUTO_WAKE && wake_ev) begin
      s_next.op = s_reg.mode[`MODE_ASE]
                  ? accel_ctrl_pkg::ST_AUTO_SLEEP
                  : accel_ctrl_pkg::ST_RUN_ACT;
    end

    // register writes
    cfg_open = s_reg.op == accel_ctrl_pkg::ST_STANDBY || in_test;
    if (wr_stb) begin
      case (wr_ofs)
        `OFS_LIMIT: begin
          if (cfg_open) begin
            s_next.limit = wr_dat;
          end
          s_next.cnt   = 8'h00;
          s_next.presc = 4'h0;
        end
        `OFS_EVEN: begin
          if (cfg_open) begin
            s_next.ev_en = wr_dat;
          end
        end
        `OFS_RATE: begin
          if (cfg_open) begin
            s_next.rate = wr_dat;
          end
        end
        `OFS_X, `OFS_Y, `OFS_Z: begin
          if (in_test) begin
            if (wr_ofs == `OFS_X) begin
              s_next.res.x = wr_dat[5:0];
            end else if (wr_ofs == `OFS_Y) begin
              s_next.res.y = wr_dat[5:0];
            end else begin
              s_next.res.z = wr_dat[5:0];
            end
            ev_smp = s_reg.ev_en[`EN_SMP];
          end
        end
        `OFS_MODE: begin
          mode_touch  = 1'b1;
          s_next.res  = '0;
          s_next.tilt = `RST_BYTE;
          s_next.mode = wr_dat;
          unique case (s_reg.op)
            accel_ctrl_pkg::ST_STANDBY: begin
              if (wr_dat[`MODE_RUN] && !wr_dat[`MODE_TEST]) begin
                s_next.op = wr_dat[`MODE_ASE]
                            ? accel_ctrl_pkg::ST_AUTO_SLEEP
                            : accel_ctrl_pkg::ST_RUN_ACT;
              end else if (!wr_dat[`MODE_RUN] && wr_dat[`MODE_TEST]) begin
                s_next.op = accel_ctrl_pkg::ST_TEST;
              end else begin
                s_next.op = accel_ctrl_pkg::ST_STANDBY;
              end
            end
            accel_ctrl_pkg::ST_TEST: begin
              // run refused while test is on
              s_next.op = wr_dat[`MODE_TEST]
                          ? accel_ctrl_pkg::ST_TEST
                          : accel_ctrl_pkg::ST_STANDBY;
            end
            default: begin
              if (wr_dat[`MODE_RUN] && !wr_dat[`MODE_TEST]) begin
                s_next.op = wr_dat[`MODE_ASE]
                            ? accel_ctrl_pkg::ST_AUTO_SLEEP
                            : accel_ctrl_pkg::ST_RUN_ACT;
              end else begin
                // test request from active lands in standby
                s_next.op = accel_ctrl_pkg::ST_STANDBY;
              end
            end
          endcase
          s_next.mode[`MODE_RUN]  = s_next.op != accel_ctrl_pkg::ST_STANDBY
                                    && s_next.op != accel_ctrl_pkg::ST_TEST;
          s_next.mode[`MODE_TEST] = s_next.op == accel_ctrl_pkg::ST_TEST;
          s_next.mode[1]          = 1'b0;
        end
        default: begin
        end
      endcase
    end

    // restart of sleep timing
    if (mode_touch || wake_ev) begin
      s_next.cnt   = 8'h00;
      s_next.presc = 4'h0;
    end

    // held event, new event beats release
    if (ev_fb || ev_pl || ev_tap || ev_shake || ev_smp || ev_slp) begin
      s_next.ev_hold = 1'b1;
    end else if (ev_release) begin
      s_next.ev_hold = 1'b0;
    end

    s_next.sps = sps_of(s_next.rate[2:0]);
    // flags kept in flops so the status pins carry no decode glitches
    s_next.act_on  = s_next.op == accel_ctrl_pkg::ST_RUN_ACT
                     || s_next.op == accel_ctrl_pkg::ST_AUTO_SLEEP;
    s_next.wake_on = s_next.op == accel_ctrl_pkg::ST_RUN_WAKE
                     || s_next.op == accel_ctrl_pkg::ST_AUTO_WAKE;
  end

  ////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg          <= '0;
      s_reg.op       <= accel_ctrl_pkg::ST_STANDBY;
      s_reg.ph       <= accel_ctrl_pkg::PH_IDLE;
      s_reg.scl_q    <= 1'b1;
      s_reg.sda_q    <= 1'b1;
      s_reg.sda_oe_n <= 1'b1;
      s_reg.sps      <= 8'h78;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // event pin

  event_pin_driver pin_drv (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .asserted  (s_reg.ev_hold),
    .polarity  (s_reg.mode[`MODE_POL]),
    .push_pull (s_reg.mode[`MODE_DRIVE]),
    .pin_out   (event_out),
    .pin_oe_n  (event_oe_n)
  );

  ////////////////////////////////////////////////////////////////
  // outputs

  // the data line is only ever pulled low
  assign sda_out            = s_reg.shift[0] & 1'b0;
  assign sda_oe_n           = s_reg.sda_oe_n;
  assign axis_results       = s_reg.res;
  assign orientation_status = s_reg.tilt;
  assign active_rate_in_use = s_reg.act_on;
  assign wake_rate_in_use   = s_reg.wake_on;
  assign active_rate_sps    = s_reg.sps;

endmodule : accel_mode_sleep_event_ctrl

//--- tb/i2c_host_model.sv
`timescale 1ns/1ps
`include "accel_ctrl_defines.svh"
module i2c_host_model (
  input  wire logic core_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge core_clk);
  endtask : hw
  // data moves only while scl is low, two cycles clear of each scl edge
  task automatic put_bit(input logic b, output logic got);
    sda_drv = b;
    hw(2);
    scl = 1'b1;
    hw(4);
    got = sda;
    scl = 1'b0;
    hw(2);
  endtask : put_bit
  // ninth bit is always released: acks from the device, nack for reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], g);
      q[i] = g;
    end
    put_bit(1'b1, g);
  endtask : xfer
  task automatic start();
    sda_drv = 1'b1;
    scl = 1'b1;
    hw(2);
    sda_drv = 1'b0;
    hw(2);
    scl = 1'b0;
    hw(2);
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    hw(2);
    scl = 1'b1;
    hw(2);
    sda_drv = 1'b1;
    hw(4);
  endtask : stop
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] q;
    start();
    xfer({`DEV_ADDR, 1'b0}, q);
    xfer(a, q);
    xfer(v, q);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    logic [7:0] q;
    start();
    xfer({`DEV_ADDR, 1'b0}, q);
    xfer(a, q);
    stop();
    start();
    xfer({`DEV_ADDR, 1'b1}, q);
    xfer(8'hff, v);
    stop();
  endtask : rd
endmodule : i2c_host_model

//--- tb/accel_ctrl_assertions.sv
`timescale 1ns/1ps
module accel_ctrl_assertions (
  input wire logic                          core_clk,
  input wire logic                          resetn,
  input wire logic                          scl_in,
  input wire logic                          sda_in,
  input wire logic                          sda_out,
  input wire logic                          sda_oe_n,
  input wire accel_ctrl_pkg::sense_in_t     sense,
  input wire accel_ctrl_pkg::axis_results_t axis_results,
  input wire logic [7:0]                    orientation_status,
  input wire logic                          active_rate_in_use,
  input wire logic                          wake_rate_in_use,
  input wire logic [7:0]                    active_rate_sps,
  input wire logic                          event_out,
  input wire logic                          event_oe_n
);
  logic [2:0] ack_q;
  logic [2:0] tick_q;
  logic [2:0] orient_q;
  logic       ack_rc;
  logic       tick_rc;
  logic       orient_rc;
  // causes stay visible for three cycles: registers and the pin lag them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 3'h0;
      tick_q <= 3'h0;
      orient_q <= 3'h0;
    end else begin
      ack_q <= {ack_q[1:0], !sda_oe_n};
      tick_q <= {tick_q[1:0], sense.sample_tick};
      orient_q <= {orient_q[1:0], sense.orient_valid};
    end
  end
  assign ack_rc = !sda_oe_n || (ack_q != 3'h0);
  assign tick_rc = sense.sample_tick || (tick_q != 3'h0);
  assign orient_rc = sense.orient_valid || (orient_q != 3'h0);
  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_rate_flags_excl: assert property (!(active_rate_in_use && wake_rate_in_use))
    else $error("both rate flags set");
  a_wake_after_tick: assert property ($rose(wake_rate_in_use) |-> tick_rc)
    else $error("wake rate without a sample tick");
  a_wake_from_act: assert property ($rose(wake_rate_in_use) |-> $past(active_rate_in_use))
    else $error("wake rate not entered from active rate");
  a_act_entry_cause: assert property ($rose(active_rate_in_use) |->
    ack_rc || (orient_rc && $past(wake_rate_in_use)))
    else $error("active rate entered without mode write or wake event");
  a_sps_code_set: assert property (active_rate_sps inside {8'h78, 8'h40, 8'h20, 8'h10,
    8'h08, 8'h04, 8'h02, 8'h01})
    else $error("sample rate value outside decode table");
  a_axis_change_cause: assert property ($changed(axis_results) |-> tick_rc || ack_rc)
    else $error("axis results changed without sample or host write");
  a_tilt_change_cause: assert property ($changed(orientation_status) |-> orient_rc || ack_rc)
    else $error("orientation status changed without cause");
  a_event_pin_cause: assert property ($changed({event_out, event_oe_n}) |->
    tick_rc || orient_rc || ack_rc)
    else $error("event pin moved without event or address ack");
  c_wake: cover property ($rose(wake_rate_in_use));
  c_event: cover property ($fell(event_oe_n));
  c_shake: cover property ($rose(orientation_status[7]));
endmodule : accel_ctrl_assertions
bind accel_mode_sleep_event_ctrl accel_ctrl_assertions chk (.core_clk(core_clk),
  .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .sense(sense), .axis_results(axis_results), .orientation_status(orientation_status),
  .active_rate_in_use(active_rate_in_use), .wake_rate_in_use(wake_rate_in_use),
  .active_rate_sps(active_rate_sps), .event_out(event_out), .event_oe_n(event_oe_n));

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
  logic                          core_clk = 1'b0;
  logic                          resetn = 1'b0;
  logic                          scl;
  logic                          sda_drv;
  logic                          sda_out;
  logic                          sda_oe_n;
  logic                          act;
  logic                          wake;
  logic                          ev_out;
  logic                          ev_oe_n;
  logic [7:0]                    tilt;
  logic [7:0]                    sps;
  logic [7:0]                    v;
  accel_ctrl_pkg::sense_in_t     sense = '0;
  accel_ctrl_pkg::axis_results_t axis;
  int                            n_fail = 0;
  int                            tests_run = 0;
  // sda has a pull-up: low if either side pulls
  wire sda = sda_drv & (sda_oe_n | sda_out);
  always #12.5 core_clk = ~core_clk;
  i2c_host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  accel_mode_sleep_event_ctrl uut (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sense(sense),
    .axis_results(axis), .orientation_status(tilt), .active_rate_in_use(act),
    .wake_rate_in_use(wake), .active_rate_sps(sps), .event_out(ev_out), .event_oe_n(ev_oe_n));
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    check(v, e);
  endtask : rchk
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge core_clk) sense.sample_tick = 1'b1;
      @(negedge core_clk) sense.sample_tick = 1'b0;
      repeat (3) @(negedge core_clk);
    end
  endtask : tick
  task automatic orient(input logic [1:0] fb, input logic [2:0] ud, input logic tp,
                        input logic [2:0] sh);
    @(negedge core_clk);
    sense.orient_valid = 1'b1;
    sense.front_back = fb;
    sense.up_down = ud;
    sense.tap = tp;
    sense.shake_xyz = sh;
    @(negedge core_clk) sense.orient_valid = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask : orient
  task automatic complete_run();
    $display("checks %0d, failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // whole sequence needs roughly 0.23 ms
  initial begin
    #2_000_000;
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (5) @(negedge core_clk);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    rchk(8'h04, 8'h00);
    rchk(8'h05, 8'h00);
    rchk(8'h06, 8'h00);
    rchk(8'h07, 8'h00);
    rchk(8'h1f, 8'h00);
    $display("test reset done");
    host.wr(8'h05, 8'h03);
    host.wr(8'h04, 8'h55);
    host.wr(8'h08, 8'h01);
    rchk(8'h05, 8'h03);
    rchk(8'h04, 8'h00);
    check(sps, 8'h40);
    host.wr(8'h07, 8'hc4);
    rchk(8'h07, 8'hc4);
    host.wr(8'h06, 8'h10);
    host.wr(8'h00, 8'h15);
    check(8'(axis.x), 8'h15);
    check({6'h0, ev_out, ev_oe_n}, 8'h02);
    rchk(8'h00, 8'h15);
    check({6'h0, ev_out, ev_oe_n}, 8'h00);
    host.wr(8'h06, 8'h00);
    host.wr(8'h01, 8'h2a);
    check(8'(ev_out), 8'h00);
    host.wr(8'h07, 8'h01);
    rchk(8'h07, 8'h00);
    check(8'(axis), 8'h00);
    check(8'(ev_oe_n), 8'h01);
    $display("test self-test mode done");
    host.wr(8'h06, 8'h86);
    host.wr(8'h07, 8'h01);
    check({6'h0, act, wake}, 8'h02);
    orient(2'h0, 3'h0, 1'b0, 3'h1);
    check({tilt[7], ev_oe_n}, 8'h01);
    orient(2'h0, 3'h0, 1'b0, 3'h4);
    check({tilt[7], ev_oe_n}, 8'h02);
    rchk(8'h04, 8'h01);
    orient(2'h0, 3'h6, 1'b0, 3'h0);
    check({tilt[4:2], ev_oe_n}, 8'h0c);
    rchk(8'h04, 8'h01);
    orient(2'h0, 3'h6, 1'b1, 3'h0);
    check({tilt[5], ev_oe_n}, 8'h02);
    host.wr(8'h07, 8'h04);
    rchk(8'h07, 8'h00);
    check(8'(act), 8'h00);
    $display("test active mode done");
    host.wr(8'h06, 8'h09);
    host.wr(8'h07, 8'h19);
    check(8'(act), 8'h01);
    tick(2);
    host.wr(8'h05, 8'hff);
    tick(3);
    check(8'(wake), 8'h00);
    tick(1);
    check({6'h0, act, wake}, 8'h01);
    check(8'(ev_oe_n), 8'h00);
    rchk(8'h04, 8'h02);
    orient(2'h1, 3'h0, 1'b0, 3'h0);
    check({6'h0, act, ev_oe_n}, 8'h02);
    check(tilt, 8'h01);
    $display("test auto sleep and wake done");
    host.wr(8'h07, 8'h00);
    host.wr(8'h07, 8'h39);
    tick(48);
    check(8'(act), 8'h01);
    tick(16);
    check(8'(wake), 8'h01);
    $display("test prescaler done");
    host.wr(8'h07, 8'h00);
    host.wr(8'h07, 8'h11);
    tick(4);
    check({6'h0, act, wake}, 8'h01);
    // no auto-wake: an orientation event must not leave the wake rate
    orient(2'h2, 3'h0, 1'b0, 3'h0);
    check({6'h0, act, wake}, 8'h01);
    $display("test sleep without auto-wake done");
    complete_run();
  end
endmodule : tb
